// ---- design/conv_port_seq.sv ----
// Converter port sequencer with AXI4-Lite registers
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module conv_port_seq #(
    parameter int HOLD_W = 8
) (
    input  wire logic                             clk,                  // 10 MHz clock
    input  wire logic                             rst_n,                // Async reset, low
    input  wire logic [conv_seq_pkg::ADDR_W-1:0]  s_axi_awaddr,         // Write address
    input  wire logic                             s_axi_awvalid,        // Write address valid
    output logic                                  s_axi_awready,        // Write address ready
    input  wire logic [31:0]                      s_axi_wdata,          // Write data
    input  wire logic [3:0]                       s_axi_wstrb,          // Byte enables
    input  wire logic                             s_axi_wvalid,         // Write data valid
    output logic                                  s_axi_wready,         // Write data ready
    output logic [1:0]                            s_axi_bresp,          // Write response
    output logic                                  s_axi_bvalid,         // Write response valid
    input  wire logic                             s_axi_bready,         // Write response ready
    input  wire logic [conv_seq_pkg::ADDR_W-1:0]  s_axi_araddr,         // Read address
    input  wire logic                             s_axi_arvalid,        // Read address valid
    output logic                                  s_axi_arready,        // Read address ready
    output logic [31:0]                           s_axi_rdata,          // Read data
    output logic [1:0]                            s_axi_rresp,          // Read response
    output logic                                  s_axi_rvalid,         // Read data valid
    input  wire logic                             s_axi_rready,         // Read data ready
    input  wire logic [7:0]                       port_data_in,         // Port lines, sensed
    output logic [7:0]                            port_data_out,        // Port lines, driven
    output logic                                  port_data_oe,         // Port lines driven
    output logic                                  port_output_enable,   // Port direction control
    output logic                                  port_direction_line,  // Direction latch bit
    output logic                                  adc_start_latch_line, // ADC start strobe
    output logic                                  adc_read_enable_line, // ADC output enable
    output logic                                  dac_zero_select_line, // DAC zero select
    output logic                                  dac_one_select_line,  // DAC one select
    output logic                                  dac_transfer_line,    // DAC shared transfer
    output logic                                  registered_path_select, // Held low
    output logic                                  outbound_latch_clock, // Unused, low
    output logic                                  inbound_latch_clock,  // Unused, low
    output logic                                  busy                  // Operation running
);
    import conv_seq_pkg::*;
    typedef enum logic [4:0] {
        S_IDLE, A_LOW, A_DIR, A_CHAN, A_STH, A_STL, A_WAIT, A_IN, A_RDH, A_RDL,
        D_LOW, D_B0, D_S0H, D_S0L, D_B1, D_S1H, D_S1L, D_XH, D_XL
    } state_t;
    initial begin
        if (HOLD_W < 1 || HOLD_W > TMR_W) $error("HOLD_W out of range");
        if (ADC_WAIT_CYC >= (1 << TMR_W)) $error("Timer too narrow for wait");
    end
    // ****************************************
    // Line and data decode per step
    // ****************************************
    function automatic logic [7:0] lines_of(state_t s, logic [7:0] man);
        logic [7:0] v;
        v = 8'h00;
        unique case (s)
            S_IDLE:                      v = man & LINES_MASK;            // RULE_16
            A_LOW, A_IN, A_RDL, D_LOW:   v = 8'h00;                      // RULE_01 RULE_05 RULE_07 RULE_10
            A_DIR, A_CHAN, A_STL, A_WAIT: v[LN_DIR] = 1'b1;              // RULE_02
            A_STH:                       v = 8'h44;                      // RULE_03
            A_RDH:                       v[LN_RDEN] = 1'b1;              // RULE_06
            D_B0, D_S0L, D_B1, D_S1L, D_XL: v[LN_DIR] = 1'b1;
            D_S0H:                       v = 8'h05;                      // RULE_11
            D_S1H:                       v = 8'h06;                      // RULE_12
            D_XH:                        v = 8'h0C;                      // RULE_13 RULE_14
        endcase
        return v;
    endfunction
    function automatic logic [7:0] data_of(state_t s, logic [7:0] chan, logic [7:0] b0,
                                           logic [7:0] b1, logic [7:0] cur);
        logic [7:0] v;
        v = cur;
        unique case (s)
            A_CHAN:              v = chan;                                // RULE_02
            D_B0:                v = b0;                                  // RULE_11
            D_B1:                v = b1;                                  // RULE_12
            default:             v = cur;
        endcase
        return v;
    endfunction
    // ****************************************
    // Registers
    // ****************************************
    state_t              state_q, state_d;
    logic [7:0]          lines_q, lines_d;
    logic [7:0]          data_q;
    logic                oe_q;
    logic [CHAN_W-1:0]   chan_q;
    logic [7:0]          dac0_q, dac1_q, result_q, manual_q;
    logic [HOLD_W-1:0]   hold_q;
    logic                done_q, busy_q;
    logic                aw_got_q, w_got_q;
    logic [ADDR_W-1:0]   awaddr_q;
    logic [31:0]         wdata_q;
    logic                wstrb0_q;
    logic                awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]          bresp_q, rresp_q;
    logic [31:0]         rdata_q;
    // ****************************************
    // Bus decode
    // ****************************************
    wire aw_hs   = s_axi_awvalid && awready_q;
    wire w_hs    = s_axi_wvalid && wready_q;
    wire wr_fire = aw_got_q && w_got_q && !bvalid_q;
    wire wr_ok   = wr_fire && wstrb0_q;
    wire ar_hs   = s_axi_arvalid && arready_q;
    wire idle    = (state_q == S_IDLE);
    wire wr_ctrl = wr_ok && awaddr_q == OFS_CTRL;
    wire go_adc  = wr_ctrl && idle && wdata_q[CTRL_ADC];                  // RULE_19
    wire go_dac  = wr_ctrl && idle && wdata_q[CTRL_DAC] && !wdata_q[CTRL_ADC];
    wire wr_hit  = awaddr_q inside {OFS_CTRL, OFS_STATUS, OFS_CHAN, OFS_DAC0,
                                    OFS_DAC1, OFS_RESULT, OFS_HOLD, OFS_LINES};
    wire rd_hit  = s_axi_araddr inside {OFS_CTRL, OFS_STATUS, OFS_CHAN, OFS_DAC0,
                                        OFS_DAC1, OFS_RESULT, OFS_HOLD, OFS_LINES};
    wire [31:0] rd_mux =
        (s_axi_araddr == OFS_STATUS) ? {30'h0, done_q, !idle} :
        (s_axi_araddr == OFS_CHAN)   ? {29'h0, chan_q} :
        (s_axi_araddr == OFS_DAC0)   ? {24'h0, dac0_q} :
        (s_axi_araddr == OFS_DAC1)   ? {24'h0, dac1_q} :
        (s_axi_araddr == OFS_RESULT) ? {24'h0, result_q} :
        (s_axi_araddr == OFS_HOLD)   ? {{(32-HOLD_W){1'b0}}, hold_q} :
        (s_axi_araddr == OFS_LINES)  ? {24'h0, manual_q} : 32'h0;
    // ****************************************
    // Step timer
    // ****************************************
    logic              tmr_done, adv;
    wire [TMR_W-1:0]   hold_ext = TMR_W'(hold_q);
    wire [TMR_W-1:0]   hold_m1  = (hold_q == '0) ? '0 : hold_ext - 1'b1;  // RULE_20
    wire [TMR_W-1:0]   load_val = (state_d == A_WAIT) ? TMR_W'(ADC_WAIT_CYC - 1) : hold_m1; // RULE_04
    hold_timer #(.W(TMR_W)) u_timer (
        .clk      (clk),
        .rst_n    (rst_n),
        .load     (adv),
        .load_val (load_val),
        .done     (tmr_done)
    );
    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        state_d = state_q;
        adv     = 1'b0;
        if (go_adc || go_dac) begin                                       // RULE_19
            state_d = go_adc ? A_LOW : D_LOW;
            adv     = 1'b1;
        end else if (!idle && tmr_done) begin
            adv = 1'b1;
            unique case (state_q)
                A_LOW:   state_d = A_DIR;
                A_DIR:   state_d = A_CHAN;
                A_CHAN:  state_d = A_STH;
                A_STH:   state_d = A_STL;
                A_STL:   state_d = A_WAIT;
                A_WAIT:  state_d = A_IN;
                A_IN:    state_d = A_RDH;
                A_RDH:   state_d = A_RDL;
                D_LOW:   state_d = D_B0;
                D_B0:    state_d = D_S0H;
                D_S0H:   state_d = D_S0L;
                D_S0L:   state_d = D_B1;
                D_B1:    state_d = D_S1H;
                D_S1H:   state_d = D_S1L;
                D_S1L:   state_d = D_XH;
                D_XH:    state_d = D_XL;
                default: state_d = S_IDLE;
            endcase
        end
    end
    assign lines_d = lines_of(state_d, manual_q);
    wire capture   = (state_q == A_RDH) && tmr_done;                      // RULE_06
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= S_IDLE;
            busy_q   <= 1'b0;
            lines_q  <= 8'h00;
            data_q   <= 8'h00;
            oe_q     <= 1'b0;
            result_q <= 8'h00;
            done_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            busy_q   <= (state_d != S_IDLE);                              // RULE_19
            lines_q  <= lines_d;                                          // RULE_09
            data_q   <= data_of(state_d, {5'h0, chan_q}, dac0_q, dac1_q, data_q);
            oe_q     <= lines_d[LN_DIR] && !lines_d[LN_RDEN];             // RULE_17 RULE_19
            if (capture) result_q <= port_data_in;                        // RULE_08
            if (capture) begin
                done_q <= 1'b1;
            end else if (wr_ok && awaddr_q == OFS_STATUS && wdata_q[ST_DONE]) begin
                done_q <= 1'b0;
            end
        end
    end
    // ****************************************
    // Register writes and bus handshakes
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_q    <= '0;
            dac0_q    <= 8'h00;
            dac1_q    <= 8'h00;
            manual_q  <= 8'h00;
            hold_q    <= HOLD_W'(HOLD_RST);
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0;
            wstrb0_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_got_q  <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
                awready_q <= 1'b0;
            end
            if (w_hs) begin
                w_got_q  <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
                wready_q <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
            if (wr_ok && awaddr_q == OFS_CHAN)  chan_q   <= wdata_q[CHAN_W-1:0]; // RULE_08
            if (wr_ok && awaddr_q == OFS_DAC0)  dac0_q   <= wdata_q[7:0];
            if (wr_ok && awaddr_q == OFS_DAC1)  dac1_q   <= wdata_q[7:0];
            if (wr_ok && awaddr_q == OFS_HOLD)  hold_q   <= wdata_q[HOLD_W-1:0];
            if (wr_ok && awaddr_q == OFS_LINES) manual_q <= wdata_q[7:0] & LINES_MASK; // RULE_16
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0;
            rresp_q   <= RESP_OKAY;
        end else if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_mux;
            rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end
    // ****************************************
    // Outputs
    // ****************************************
    assign s_axi_awready          = awready_q;
    assign s_axi_wready           = wready_q;
    assign s_axi_bvalid           = bvalid_q;
    assign s_axi_bresp            = bresp_q;
    assign s_axi_arready          = arready_q;
    assign s_axi_rvalid           = rvalid_q;
    assign s_axi_rdata            = rdata_q;
    assign s_axi_rresp            = rresp_q;
    assign port_data_out          = data_q;
    assign port_data_oe           = oe_q;
    assign port_output_enable     = lines_q[LN_DIR];
    assign port_direction_line    = lines_q[LN_DIR];
    assign adc_start_latch_line   = lines_q[LN_START];
    assign adc_read_enable_line   = lines_q[LN_RDEN];
    assign dac_zero_select_line   = lines_q[LN_SEL0];
    assign dac_one_select_line    = lines_q[LN_SEL1];
    assign dac_transfer_line      = lines_q[LN_LATCH_TO_OUTPUT_TRANSFER];
    assign registered_path_select = lines_q[4];                           // RULE_18
    assign outbound_latch_clock   = lines_q[5];
    assign inbound_latch_clock    = lines_q[5];
    assign busy                   = busy_q;
    // ****************************************
    // Checks
    // ****************************************
    logic [TMR_W-1:0] since_start_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            since_start_q <= '0;
        end else if (adc_start_latch_line) begin
            since_start_q <= '0;
        end else if (since_start_q != '1) begin
            since_start_q <= since_start_q + 1'b1;
        end
    end
    a_low_before_conv: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        state_q == A_LOW |-> !port_direction_line && !adc_start_latch_line && !adc_read_enable_line)
        else $error("ADC lines not low at start");
    a_chan_on_bus: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        (busy && $rose(adc_start_latch_line)) |-> port_data_oe && port_data_out == {5'h0, chan_q})
        else $error("Channel not on bus at start");
    a_start_returns: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
        (busy && $rose(adc_start_latch_line)) |-> ##[1:300] !adc_start_latch_line)
        else $error("Start strobe stuck high");
    a_conv_wait: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
        (busy && $rose(adc_read_enable_line)) |-> since_start_q >= TMR_W'(ADC_WAIT_CYC))
        else $error("Result read too early");
    a_no_bus_fight: assert property (@(posedge clk) disable iff (!rst_n) // RULE_19
        adc_read_enable_line |-> !port_data_oe && !(busy && port_direction_line))
        else $error("Port driven while ADC enabled");
    a_capture_byte: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
        capture |=> result_q == $past(port_data_in) && done_q)
        else $error("Result byte not captured");
    a_rden_release: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
        (busy && $rose(adc_read_enable_line)) |-> ##[1:300] !adc_read_enable_line)
        else $error("Read enable not released");
    a_sel0_data: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
        (busy && $rose(dac_zero_select_line)) |-> port_data_oe && port_data_out == dac0_q)
        else $error("DAC zero byte missing at select");
    a_sel1_data: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
        (busy && $rose(dac_one_select_line)) |-> port_data_out == dac1_q && !dac_zero_select_line)
        else $error("DAC one byte missing at select");
    a_latch_to_output_transfer_after: assert property (@(posedge clk) disable iff (!rst_n) // RULE_14
        (busy && $rose(dac_transfer_line)) |-> !dac_zero_select_line && !dac_one_select_line
            && $past(dac_one_select_line, 2) == 1'b0)
        else $error("Transfer overlaps a select");
    a_lines_disjoint: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
        busy |-> !((dac_zero_select_line || dac_one_select_line || dac_transfer_line)
                   && (adc_start_latch_line || adc_read_enable_line)))
        else $error("ADC and DAC lines overlap");
    a_manual_follow: assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
        (!busy && $past(!busy)) |-> lines_q == $past(manual_q))
        else $error("Idle lines differ from software value");
    a_path_low: assert property (@(posedge clk) disable iff (!rst_n) // RULE_18
        !registered_path_select && !outbound_latch_clock && !inbound_latch_clock)
        else $error("Unused port controls not low");
endmodule

// ---- design/conv_seq_pkg.sv ----
// Constants shared by the converter port sequencer
// Functional notes
// [RULE_01] Direction, start, read-enable low before conversion
// [RULE_02] Drive port outward, then present channel index
// [RULE_03] Pulse start high then low
// [RULE_04] Wait at least 120 us after start
// [RULE_05] Turn port inbound before reading result
// [RULE_06] Raise read-enable, capture byte from port
// [RULE_07] Lower read-enable, sequencer ready again
// [RULE_08] Eight channels, eight-bit unsigned results
// [RULE_09] Port is data bus, latch bits strobe
// [RULE_10] Both selects and transfer low before update
// [RULE_11] Pulse select zero with byte zero present
// [RULE_12] Pulse select one with byte one present
// [RULE_13] Loading latch leaves analog output unchanged
// [RULE_14] After both loads pulse shared transfer line
// [RULE_15] Input and output paths use disjoint lines
// [RULE_16] Latch bits follow software written levels
// [RULE_17] Output enable sets port data direction
// [RULE_18] Path select low, latch clocks unused
// [RULE_19] One operation, busy flag, no bus fight
// [RULE_20] Each strobe level held configurable cycles
package conv_seq_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_CHAN    = 8'h08;
    localparam logic [7:0]  OFS_DAC0    = 8'h0C;
    localparam logic [7:0]  OFS_DAC1    = 8'h10;
    localparam logic [7:0]  OFS_RESULT  = 8'h14;
    localparam logic [7:0]  OFS_HOLD    = 8'h18;
    localparam logic [7:0]  OFS_LINES   = 8'h1C;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int          CTRL_ADC    = 0;
    localparam int          CTRL_DAC    = 1;
    localparam int          ST_BUSY     = 0;
    localparam int          ST_DONE     = 1;
    localparam int          LN_SEL0     = 0;
    localparam int          LN_SEL1     = 1;
    localparam int          LN_DIR      = 2;
    localparam int          LN_LATCH_TO_OUTPUT_TRANSFER     = 3;
    localparam int          LN_START    = 6;
    localparam int          LN_RDEN     = 7;
    localparam logic [7:0]  LINES_MASK  = 8'hCF;
    localparam int          CHAN_W      = 3;
    // ****************************************
    // Reset values and responses
    // ****************************************
    localparam logic [7:0]  HOLD_RST    = 8'h04;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // ****************************************
    // Timing
    // ****************************************
    localparam int          CLK_NS      = 100;
    localparam int          ADC_WAIT_NS = 120000;
    localparam int          ADC_WAIT_CYC = (ADC_WAIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int          TMR_W       = 16;
endpackage

// ---- design/hold_timer.sv ----
// Down counter that times each sequencer step
`timescale 1ns/1ps
module hold_timer #(
    parameter int W = 16
) (
    input  wire logic         clk,      // System clock
    input  wire logic         rst_n,    // Async reset, low
    input  wire logic         load,     // Start a new interval
    input  wire logic [W-1:0] load_val, // Cycles minus one
    output logic              done      // Interval over
);
    logic [W-1:0] cnt_q;

    initial begin
        if (W < 2) $error("hold_timer width too small");
    end

    assign done = (cnt_q == '0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= load_val;
        end else if (!done) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

// ---- sim/conv_partner.sv ----
// Behavioural model of the external converter chips
`timescale 1ns/1ps
module conv_partner (
    input  wire logic [7:0] bus,   // Resolved port lines
    input  wire logic       start, // Conversion start
    input  wire logic       rden,  // Result enable
    input  wire logic       sel0,  // Output zero select
    input  wire logic       sel1,  // Output one select
    input  wire logic       latch_to_output_transfer,  // Shared transfer
    output logic      [7:0] drv,   // Lines from the ADC
    output logic      [7:0] dac0,  // Output zero level
    output logic      [7:0] dac1   // Output one level
);
    logic [2:0] chan_q = 3'h0;
    logic [7:0] lat0_q = 8'h00;
    logic [7:0] lat1_q = 8'h00;
    initial begin
        dac0 = 8'h00;
        dac1 = 8'h00;
    end
    // Released bus shows the inverse, so a late capture fails
    assign drv = rden ? (8'hC0 | {5'h00, chan_q}) : ~(8'hC0 | {5'h00, chan_q});
    always @(posedge start) chan_q <= bus[2:0];
    always @(negedge sel0) lat0_q <= bus;
    always @(negedge sel1) lat1_q <= bus;
    always @(posedge latch_to_output_transfer) begin
        dac0 <= lat0_q;
        dac1 <= lat1_q;
    end
endmodule

// ---- sim/tb_adc_dac_port_sequencer.sv ----
// Self-checking bench for the converter port sequencer
`timescale 1ns/1ps
module tb_adc_dac_port_sequencer;
    import conv_seq_pkg::*;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [7:0] awa = 8'h00, ara = 8'h00, pdi, pdo, adq, d0, d1;
    logic [31:0] wd = 32'h0, rd;
    logic [1:0] br, rr;
    logic awr, wrd, bv, arr, rv, oe, poe, dir, st, re, s0, s1, xf, rps, olc, ilc, busy;
    int miscompares = 0, n_checks = 0, cyc = 0;
    assign pdi = oe ? pdo : adq;
    conv_port_seq dut_u (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .port_data_in(pdi),
        .port_data_out(pdo), .port_data_oe(oe), .port_output_enable(poe), .port_direction_line(dir),
        .adc_start_latch_line(st), .adc_read_enable_line(re), .dac_zero_select_line(s0),
        .dac_one_select_line(s1), .dac_transfer_line(xf), .registered_path_select(rps),
        .outbound_latch_clock(olc), .inbound_latch_clock(ilc), .busy(busy));
    conv_partner far_u (.bus(pdi), .start(st), .rden(re), .sel0(s0), .sel1(s1), .latch_to_output_transfer(xf), .drv(adq),
        .dac0(d0), .dac1(d1));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic complete_run;
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa = 1, pw = 1;
        awa <= a;
        wd <= d;
        {awv, wv, bry} <= 3'b111;
        while (pa || pw) begin
            @(posedge clk);
            if (awr) pa = 0;
            if (wrd) pw = 0;
            awv <= pa;
            wv <= pw;
        end
        while (bv !== 1) @(posedge clk);
        bry <= 0;
        chk(br, er);
        @(posedge clk);
    endtask
    task automatic rg(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        ara <= a;
        {arv, rry} <= 2'b11;
        @(posedge clk);
        while (arr !== 1) @(posedge clk);
        arv <= 0;
        while (rv !== 1) @(posedge clk);
        rry <= 0;
        v = rd;
        r = rr;
        @(posedge clk);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (oe && re) chk(0, 1);
        if (busy && (st || re) && (s0 || s1 || xf)) chk(0, 1);
        if (cyc == 40000) begin
            miscompares++;
            complete_run;
        end
    end
    task automatic t_reset;
        logic [31:0] v;
        logic [1:0] r;
        chk({rps, olc, ilc, dir, st, re, s0, s1, xf}, 0);
        rg(OFS_HOLD, v, r);
        chk(v, HOLD_RST);
        rg(8'h20, v, r);
        chk(r, RESP_SLVERR);
        wr(8'h20, 32'h1, RESP_SLVERR);
    endtask
    task automatic t_lines;
        logic [31:0] v;
        logic [1:0] r;
        wr(OFS_LINES, 32'hFF, RESP_OKAY);
        rg(OFS_LINES, v, r);
        chk(v, LINES_MASK);
        chk({re, st, xf, dir, poe, s1, s0}, 7'h7F);
        wr(OFS_LINES, 32'h0, RESP_OKAY);
        rg(OFS_LINES, v, r);
        chk({re, st, xf, dir, poe, s1, s0}, 0);
    endtask
    task automatic t_adc(input logic [2:0] ch);
        logic [31:0] v;
        logic [1:0] r;
        int n = 0;
        wr(OFS_CHAN, {29'h0, ch}, RESP_OKAY);
        wr(OFS_CTRL, 32'h1, RESP_OKAY);
        while (st !== 1) @(posedge clk);
        chk({busy, oe, dir, pdo}, {3'b111, 5'h00, ch});
        while (st !== 0) @(posedge clk);
        while (re !== 1) begin
            @(posedge clk);
            n++;
        end
        chk(n >= ADC_WAIT_CYC, 1);
        chk(dir, 0);
        v = 1;
        while (v[ST_BUSY] !== 0) rg(OFS_STATUS, v, r);
        chk({v[30:0], re}, {31'h2, 1'b0});
        rg(OFS_RESULT, v, r);
        chk(v, {24'h0, 8'hC0 | {5'h00, ch}});
        wr(OFS_STATUS, 32'h2, RESP_OKAY);
    endtask
    task automatic t_dac(input logic [7:0] a, input logic [7:0] b, input logic [15:0] old);
        logic [31:0] v;
        logic [1:0] r;
        wr(OFS_DAC0, {24'h0, a}, RESP_OKAY);
        wr(OFS_DAC1, {24'h0, b}, RESP_OKAY);
        wr(OFS_CTRL, 32'h2, RESP_OKAY);
        wr(OFS_CTRL, 32'h1, RESP_OKAY);
        while (s1 !== 1) @(posedge clk);
        while (s1 !== 0) @(posedge clk);
        chk({d0, d1}, old);
        while (xf !== 1) @(posedge clk);
        v = 1;
        while (v[ST_BUSY] !== 0) rg(OFS_STATUS, v, r);
        chk({d0, d1}, {a, b});
        chk(v, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        t_reset;
        t_lines;
        for (int c = 0; c < 8; c++) t_adc(c[2:0]);
        t_dac(8'h3C, 8'hA5, 16'h0000);
        t_dac(8'h5A, 8'hC3, 16'h3CA5);
        complete_run;
    end
endmodule
